// ---- rtl/sdc_core.sv ----
// Function
// RULE1 - refresh and mode load only all idle
// RULE2 - burst terminate hits the bursting bank only
// RULE3 - interrupted auto precharge burst precharges itself
// RULE4 - new read data replaces old after CL
// RULE5 - write ends read burst at its edge
// RULE6 - read ends write; data CL later
// RULE7 - write ends write; last data one before
// RULE8 - read auto precharge: precharge at interrupt edge
// RULE9 - controller masks data two clocks before write
// RULE10 - write auto precharge: precharge after write recovery
// RULE11 - power-down exit: command accepted next edge
// RULE12 - self refresh exit: only NOPs during recovery
// RULE13 - suspend exit resumes, command next edge
// RULE14 - clock enable fall picks low power state
// RULE15 - controller waits startup delay with NOPs
// RULE16 - then precharge all banks
// RULE17 - two auto refreshes before mode load
// RULE18 - only NOPs during refresh and mode time
// RULE19 - mode undefined until loaded; load first
// RULE20 - mode fields: length, type, latency, mode, write
// RULE21 - bank bits zero select base mode register
// RULE22 - mode kept; load idle; wait mode time
// RULE23 - latency two or three; others reserved
// RULE24 - write single bit forces one-word writes
// RULE25 - normal operation only with zero mode bits
// RULE26 - burst wraps inside aligned block
// RULE27 - each bank keeps its own state
module sdc_core (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // memory pins
   input wire sdc_pkg::sdc_pins_t pins_in,
   output logic [sdc_pkg::DQ_W-1:0] dq_out,
   output logic dq_oe,
   // status
   output sdc_pkg::sdc_pwr_t pwr_state,
   output sdc_pkg::sdc_bank_st_t [3:0] bank_state,
   output logic [sdc_pkg::MR_W-1:0] mode_word,
   output logic mode_loaded,
   output logic mode_reserved
);
   import sdc_pkg::*;

   // ********************************************
   // state and decode
   // ********************************************
   sdc_state_t r;
   sdc_state_t n;
   sdc_pins_t p;
   sdc_burst_t cur;
   logic [2:0] cmd;
   logic [3:0] bk_idle;
   logic [COL_W-1:0] col;
   logic [COL_W-1:0] mask;
   logic run;
   logic rise;
   logic fall;
   logic go;
   logic adv;
   logic all_idle;
   logic acc_rw;
   logic is_rd;
   logic is_wr;
   logic bk_open;

   // pins reach decode only after two sync stages
   assign p = r.s2;
   assign cmd = p.cs_n ? CMD_NOP : {p.ras_n, p.cas_n, p.we_n};
   assign run = r.cke_q & p.cke;
   assign rise = ~r.cke_q & p.cke;
   assign fall = r.cke_q & ~p.cke;
   // refresh and mode time lock out every command
   assign go = run && r.pw == PW_RUN && r.busy == 4'h0;
   // a suspended burst holds still while clock enable is low
   assign adv = p.cke && (r.pw == PW_RUN || r.pw == PW_SUSP); // [RULE13]
   assign is_rd = cmd == CMD_RD;
   assign is_wr = cmd == CMD_WR;
   assign bk_open = r.bank[p.ba].st inside {BK_ACTV, BK_RD, BK_WR} ||
      (r.bank[p.ba].st == BK_ACTG && r.bank[p.ba].cnt == 4'h0);
   // no access before a normal-mode load of the mode register
   assign acc_rw = go && (is_rd || is_wr) && r.mode_ok && bk_open &&
      r.mode[MR_OP_LSB +: 2] == 2'h0; // [RULE19] [RULE25]

   // a bank whose precharge ends this cycle already counts as idle
   genvar gb;
   generate
      for (gb = 0; gb < 4; gb++) begin : g_bank
         assign bk_idle[gb] = r.bank[gb].st == BK_IDLE ||
            (r.bank[gb].st == BK_PRE && r.bank[gb].cnt == 4'h0);
         assign bank_state[gb] = r.bank[gb].st;
      end
   endgenerate
   assign all_idle = &bk_idle;

   // ********************************************
   // next state
   // ********************************************
   always_comb begin
      n = r;
      cur = r.bst;
      mask = '0;
      col = '0;
      n.s1 = pins_in;
      n.s2 = r.s1;
      n.cke_q = p.cke;
      // per-bank timers for activate, recovery and precharge
      for (int b = 0; b < 4; b++) begin
         case (r.bank[b].st)
            BK_ACTG, BK_REC, BK_PRE: begin
               if (r.bank[b].cnt != 4'h0) begin
                  n.bank[b].cnt = r.bank[b].cnt - 4'h1;
               end else if (r.bank[b].st == BK_ACTG) begin
                  n.bank[b].st = BK_ACTV;
               end else if (r.bank[b].st == BK_REC) begin
                  n.bank[b].st = BK_PRE; // [RULE10]
                  n.bank[b].cnt = RP_CYC - 4'h1;
               end else begin
                  n.bank[b].st = BK_IDLE; // [RULE27]
               end
            end
            default: ;
         endcase
      end
      if (r.busy != 4'h0)
         n.busy = r.busy - 4'h1;
      // clock enable transitions
      case (r.pw)
         PW_RUN: begin
            if (fall && all_idle && r.busy == 4'h0) begin
               if (cmd == CMD_NOP)
                  n.pw = PW_PDN; // [RULE14]
               else if (cmd == CMD_BST)
                  n.pw = PW_DEEP; // [RULE14]
               else if (cmd == CMD_AREF)
                  n.pw = PW_SREF; // [RULE14]
            end else if (fall && r.bst.act) begin
               n.pw = PW_SUSP; // [RULE14]
            end
         end
         PW_SREF: begin
            if (rise) begin
               n.pw = PW_XSR;
               n.busy = XSR_CYC - 4'h1;
            end
         end
         PW_XSR: begin
            if (r.busy == 4'h0)
               n.pw = PW_RUN;
         end
         default: begin
            // leave power-down, deep sleep or suspend
            if (rise)
               n.pw = PW_RUN; // [RULE11] [RULE13]
         end
      endcase
      // read pipeline and output stage, frozen while suspended
      if (adv) begin
         n.rp[0] = r.rp[1];
         n.rp[1] = '0;
         n.dout = r.rp[0].d;
         n.dout_v = r.rp[0].v;
         n.dqm_q = p.dqm;
         n.oe = r.rp[0].v && !r.dqm_q;
      end
      // commands
      if (go) begin
         case (cmd)
            CMD_ACT: begin
               if (bk_idle[p.ba]) begin
                  n.bank[p.ba].st = BK_ACTG; // [RULE27]
                  n.bank[p.ba].cnt = RCD_CYC - 4'h1;
               end
            end
            CMD_RD, CMD_WR: begin
               if (acc_rw) begin
                  if (r.bst.act) begin
                     // the interrupted bank lets go of its burst
                     if (r.bst.ap && r.bst.wr) begin
                        n.bank[r.bst.bank].st = BK_REC; // [RULE3] [RULE10]
                        n.bank[r.bst.bank].cnt = WR_CYC - 4'h1;
                     end else if (r.bst.ap) begin
                        n.bank[r.bst.bank].st = BK_PRE; // [RULE3] [RULE8]
                        n.bank[r.bst.bank].cnt = RP_CYC - 4'h1;
                     end else begin
                        n.bank[r.bst.bank].st = BK_ACTV; // [RULE6] [RULE7]
                     end
                     // read data still queued would collide with write data
                     if (is_wr && !r.bst.wr) begin
                        n.rp[0].v = 1'b0; // [RULE5]
                        n.rp[1].v = 1'b0;
                     end
                  end
                  n.bank[p.ba].st = is_wr ? BK_WR : BK_RD;
                  n.bank[p.ba].ap = p.addr[AP_BIT];
                  cur.act = 1'b1;
                  cur.wr = is_wr;
                  cur.ap = p.addr[AP_BIT];
                  cur.bank = p.ba;
                  cur.start = p.addr[COL_W-1:0];
                  cur.k = '0;
                  cur.cont = 1'b0;
                  cur.len = 4'h1;
                  if (is_wr && r.mode[MR_WB_BIT]) begin
                     cur.len = 4'h1; // [RULE24]
                  end else if (r.mode[MR_BL_LSB +: 3] == BL_CONT) begin
                     cur.cont = 1'b1;
                  end else if (!r.mode[MR_BL_LSB+2]) begin
                     cur.len = 4'h1 << r.mode[MR_BL_LSB +: 2]; // [RULE20]
                  end
               end
            end
            CMD_PRE: begin
               for (int b = 0; b < 4; b++) begin
                  if ((p.addr[AP_BIT] || p.ba == 2'(b)) &&
                     r.bank[b].st inside {BK_ACTG, BK_ACTV, BK_RD, BK_WR}) begin
                     n.bank[b].st = BK_PRE;
                     n.bank[b].cnt = RP_CYC - 4'h1;
                     if (r.bst.act && r.bst.bank == 2'(b))
                        cur.act = 1'b0;
                  end
               end
            end
            CMD_AREF: begin
               if (all_idle)
                  n.busy = RFC_CYC - 4'h1; // [RULE1]
            end
            CMD_LMR: begin
               // only the base register; extended loads are not held here
               if (all_idle && p.ba == 2'h0) begin
                  n.mode = p.addr[MR_W-1:0]; // [RULE1] [RULE20] [RULE21]
                  n.mode_ok = 1'b1; // [RULE19]
                  n.busy = MRD_CYC - 4'h1; // [RULE22]
               end
            end
            CMD_BST: begin
               // bank bits are ignored: only the running burst stops
               if (r.bst.act) begin
                  cur.act = 1'b0; // [RULE2]
                  n.bank[r.bst.bank].st = BK_ACTV;
               end
            end
            default: ;
         endcase
      end
      // one burst beat per active cycle
      if (adv && cur.act) begin
         mask = cur.cont ? '1 : COL_W'(cur.len - 4'h1);
         if (r.mode[MR_BT_BIT] && !cur.cont)
            col = cur.start ^ cur.k;
         else
            col = cur.start + cur.k;
         col = (col & mask) | (cur.start & ~mask); // [RULE26]
         if (cur.wr) begin
            if (!p.dqm)
               n.mem[{cur.bank, col}] = p.dq; // [RULE6] [RULE7]
         end else if (r.mode[MR_CL_LSB +: 3] == CL3) begin
            n.rp[1] = {1'b1, r.mem[{cur.bank, col}]}; // [RULE23]
         end else begin
            n.rp[0] = {1'b1, r.mem[{cur.bank, col}]}; // [RULE4]
         end
         n.bst = cur;
         n.bst.k = cur.k + 1'b1;
         if (!cur.cont && 4'(cur.k) + 4'h1 == cur.len) begin
            n.bst.act = 1'b0;
            if (cur.ap && cur.wr) begin
               n.bank[cur.bank].st = BK_REC;
               n.bank[cur.bank].cnt = WR_CYC - 4'h1;
            end else if (cur.ap) begin
               n.bank[cur.bank].st = BK_PRE;
               n.bank[cur.bank].cnt = RP_CYC - 4'h1;
            end else begin
               n.bank[cur.bank].st = BK_ACTV;
            end
         end
      end else begin
         n.bst = cur;
      end
   end

   // ********************************************
   // registers
   // ********************************************
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         r <= '0;
         r.pw <= PW_RUN;
         for (int b = 0; b < 4; b++)
            r.bank[b].st <= BK_IDLE;
      end else begin
         r <= n;
      end
   end

   // outputs straight from state
   assign dq_out = r.dout;
   assign dq_oe = r.oe;
   assign pwr_state = r.pw;
   assign mode_word = r.mode;
   assign mode_loaded = r.mode_ok;
   // reserved latency, operating mode or burst length
   assign mode_reserved = r.mode_ok &&
      (!(r.mode[MR_CL_LSB +: 3] inside {CL2, CL3}) ||
      r.mode[MR_OP_LSB +: 2] != 2'h0 ||
      r.mode[MR_BL_LSB +: 3] inside {3'h4, 3'h5, 3'h6}); // [RULE23]

   // ********************************************
   // checks
   // ********************************************
   a_rd_latency: // [RULE4]
   assert property (@(posedge ref_clk) disable iff (!reset_n)
      acc_rw && is_rd && r.mode[MR_CL_LSB +: 3] == CL2 ##1 p.cke
      |=> r.dout_v)
      else $error("read data late at latency two");
   a_wr_flush: // [RULE5]
   assert property (@(posedge ref_clk) disable iff (!reset_n)
      acc_rw && is_wr && r.bst.act && !r.bst.wr
      |=> !r.rp[0].v && !r.rp[1].v)
      else $error("read data left after write");
   a_rdap_pre: // [RULE8]
   assert property (@(posedge ref_clk) disable iff (!reset_n)
      acc_rw && r.bst.act && r.bst.ap && !r.bst.wr && p.ba != r.bst.bank
      |=> r.bank[$past(r.bst.bank)].st == BK_PRE)
      else $error("interrupted read did not precharge");
   a_wrap_rec: // [RULE10]
   assert property (@(posedge ref_clk) disable iff (!reset_n)
      acc_rw && r.bst.act && r.bst.ap && r.bst.wr && p.ba != r.bst.bank
      |=> r.bank[$past(r.bst.bank)].st == BK_REC &&
      r.bank[$past(r.bst.bank)].cnt == WR_CYC - 4'h1)
      else $error("write recovery not started");
   a_pd_exit: // [RULE11]
   assert property (@(posedge ref_clk) disable iff (!reset_n)
      r.pw == PW_PDN && rise |=> r.pw == PW_RUN)
      else $error("power-down exit too slow");
   a_susp_entry: // [RULE14]
   assert property (@(posedge ref_clk) disable iff (!reset_n)
      r.pw == PW_RUN && fall && r.bst.act |=> r.pw == PW_SUSP ##1
      ($past(p.cke) || $stable(r.bst.k)))
      else $error("clock suspend not entered");
   a_aref_busy: // [RULE1]
   assert property (@(posedge ref_clk) disable iff (!reset_n)
      go && cmd == CMD_AREF && !all_idle |=> r.busy == 4'h0)
      else $error("refresh taken with open bank");
   a_bst_stop: // [RULE2]
   assert property (@(posedge ref_clk) disable iff (!reset_n)
      go && cmd == CMD_BST && r.bst.act
      |=> !r.bst.act && r.bank[$past(r.bst.bank)].st == BK_ACTV)
      else $error("burst terminate missed running bank");
   a_wr_single: // [RULE24]
   assert property (@(posedge ref_clk) disable iff (!reset_n)
      acc_rw && is_wr && r.mode[MR_WB_BIT] |=> !r.bst.act)
      else $error("single write ran as burst");
   a_mode_load: // [RULE22]
   assert property (@(posedge ref_clk) disable iff (!reset_n)
      go && cmd == CMD_LMR && all_idle && p.ba == 2'h0
      |=> r.mode == $past(p.addr[MR_W-1:0]) &&
      r.busy == MRD_CYC - 4'h1)
      else $error("mode load or lockout wrong");
endmodule

// ---- rtl/sdc_pkg.sv ----
package sdc_pkg;

   // ********************************************
   // widths and timing
   // ********************************************
   localparam int CLK_MHZ = 100;
   localparam int ADDR_W = 13;
   localparam int DQ_W = 16;
   localparam int COL_W = 3;
   localparam int WORDS = 4 << COL_W;
   // figures in ns; plain defaults, tune to the speed grade
   localparam int T_RCD_NS = 18;
   localparam int T_RP_NS = 18;
   localparam int T_WR_NS = 15;
   localparam int T_RFC_NS = 72;
   localparam int T_MRD_NS = 20;
   localparam int T_XSR_NS = 120;

   // least time, rounded up, never below one cycle
   function automatic logic [3:0] cyc(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      if (c < 1)
         c = 1;
      return 4'(c);
   endfunction

   localparam logic [3:0] RCD_CYC = cyc(T_RCD_NS);
   localparam logic [3:0] RP_CYC = cyc(T_RP_NS);
   localparam logic [3:0] WR_CYC = cyc(T_WR_NS);
   localparam logic [3:0] RFC_CYC = cyc(T_RFC_NS);
   localparam logic [3:0] MRD_CYC = cyc(T_MRD_NS);
   localparam logic [3:0] XSR_CYC = cyc(T_XSR_NS);

   // ********************************************
   // commands {ras_n, cas_n, we_n} and mode fields
   // ********************************************
   localparam logic [2:0] CMD_LMR = 3'h0;
   localparam logic [2:0] CMD_AREF = 3'h1;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_WR = 3'h4;
   localparam logic [2:0] CMD_RD = 3'h5;
   localparam logic [2:0] CMD_BST = 3'h6;
   localparam logic [2:0] CMD_NOP = 3'h7;
   localparam int AP_BIT = 10;
   localparam int MR_W = 10;
   localparam int MR_BL_LSB = 0;
   localparam int MR_BT_BIT = 3;
   localparam int MR_CL_LSB = 4;
   localparam int MR_OP_LSB = 7;
   localparam int MR_WB_BIT = 9;
   localparam logic [2:0] BL_CONT = 3'h7;
   localparam logic [2:0] CL2 = 3'h2;
   localparam logic [2:0] CL3 = 3'h3;

   // ********************************************
   // types
   // ********************************************
   typedef enum logic [6:0] {
      BK_IDLE = 7'h01, BK_ACTG = 7'h02, BK_ACTV = 7'h04, BK_RD = 7'h08,
      BK_WR = 7'h10, BK_REC = 7'h20, BK_PRE = 7'h40
   } sdc_bank_st_t;
   typedef enum logic [5:0] {
      PW_RUN = 6'h01, PW_PDN = 6'h02, PW_SREF = 6'h04, PW_DEEP = 6'h08,
      PW_SUSP = 6'h10, PW_XSR = 6'h20
   } sdc_pwr_t;
   typedef struct packed {
      logic cke;
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [1:0] ba;
      logic [ADDR_W-1:0] addr;
      logic dqm;
      logic [DQ_W-1:0] dq;
   } sdc_pins_t;
   typedef struct packed {
      sdc_bank_st_t st;
      logic ap;
      logic [3:0] cnt;
   } sdc_bank_t;
   typedef struct packed {
      logic act;
      logic wr;
      logic ap;
      logic cont;
      logic [1:0] bank;
      logic [COL_W-1:0] start;
      logic [COL_W-1:0] k;
      logic [3:0] len;
   } sdc_burst_t;
   typedef struct packed {
      logic v;
      logic [DQ_W-1:0] d;
   } sdc_rd_t;
   typedef struct packed {
      sdc_pins_t s1;
      sdc_pins_t s2;
      logic cke_q;
      sdc_pwr_t pw;
      logic [3:0] busy;
      sdc_bank_t [3:0] bank;
      logic [MR_W-1:0] mode;
      logic mode_ok;
      sdc_burst_t bst;
      sdc_rd_t [1:0] rp;
      logic [DQ_W-1:0] dout;
      logic dqm_q;
      logic dout_v;
      logic oe;
      logic [WORDS-1:0][DQ_W-1:0] mem;
   } sdc_state_t;
endpackage

// ---- verification/sdc_ctl_model.sv ----
// ****************************************
// controller model driving the memory pins
// ****************************************
module sdc_ctl_model
   import sdc_pkg::*;
   #(parameter int STARTUP_CYC = 10000)
(
   // clock
   input wire logic ref_clk,
   // pins toward the memory
   output sdc_pkg::sdc_pins_t pins
);
   timeunit 1ns;
   timeprecision 100ps;

   // inhibit with clock enable high until the first command
   initial begin
      pins = '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
         default: '0};
   end

   // one command per cycle, changed just after the edge; a deselect
   // raises cs_n so that its command code has to be ignored
   task automatic issue(input logic [2:0] c, input logic [1:0] b,
      input logic [ADDR_W-1:0] a, input logic [DQ_W-1:0] d, input logic m,
      input logic ke, input logic desel = 1'b0);
      @(posedge ref_clk);
      pins <= '{cke: ke, cs_n: desel, ras_n: c[2], cas_n: c[1], we_n: c[0],
         ba: b, addr: a, dqm: m, dq: d};
   endtask

   // released data lines flip so a stale word never looks valid
   task automatic cmd(input logic [2:0] c, input logic [1:0] b,
      input logic [ADDR_W-1:0] a, input logic m = 1'b0);
      issue(c, b, a, ~pins.dq, m, 1'b1);
   endtask

   // every second slot is a deselect dressed as a mode load
   task automatic nop(input int n, input logic ke = 1'b1);
      for (int i = 0; i < n; i++) begin
         issue(i[0] ? CMD_LMR : CMD_NOP, 2'h0, '0, ~pins.dq, 1'b0, ke,
            i[0]);
      end
   endtask

   // ****************************************
   // sequences kept by the controller side
   // ****************************************
   // callers only load while all banks are idle
   task automatic load_mode(input logic [MR_W-1:0] m);
      cmd(CMD_LMR, 2'h0, ADDR_W'(m));
      nop(int'(MRD_CYC) + 2);
   endtask

   task automatic pre_all;
      cmd(CMD_PRE, 2'h0, 13'h0400);
      nop(int'(RP_CYC) + 1);
   endtask

   // startup: wait, precharge, two refreshes, then the mode load
   task automatic init(input logic [MR_W-1:0] m);
      nop(STARTUP_CYC);
      pre_all();
      repeat (2) begin
         cmd(CMD_AREF, 2'h0, '0);
         nop(int'(RFC_CYC) + 1);
      end
      load_mode(m);
   endtask

   // raise clock enable and keep to NOPs through the recovery time
   task automatic sref_exit;
      nop(int'(XSR_CYC) + 2);
   endtask
endmodule

// ---- verification/sdc_core_bench.sv ----
// ****************************************
// bench for the memory command core
// ****************************************
`define CHK(got, exp) \
   begin \
      compares++; \
      if ((got) !== (exp)) begin \
         num_errors++; \
         $display("ERROR %0t: got %h expected %h", $time, got, exp); \
      end \
   end

module sdc_core_bench;
   import sdc_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   logic ref_clk;
   logic reset_n;
   sdc_pins_t pins;
   logic [DQ_W-1:0] dq_out;
   logic dq_oe;
   sdc_pwr_t pwr_state;
   sdc_bank_st_t [3:0] bank_state;
   logic [MR_W-1:0] mode_word;
   logic mode_loaded;
   logic mode_reserved;
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;

   sdc_ctl_model ctl_u (.ref_clk(ref_clk), .pins(pins));

   sdc_core dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .pins_in(pins),
      .dq_out(dq_out), .dq_oe(dq_oe), .pwr_state(pwr_state),
      .bank_state(bank_state), .mode_word(mode_word),
      .mode_loaded(mode_loaded), .mode_reserved(mode_reserved));

   // 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic tally_and_finish;
      if (num_errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // startup delay dominates; the rest is a few hundred cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end

   // ****************************************
   // helpers
   // ****************************************
   // words are looked at in the one cycle that they stand
   task automatic rd_words(input int skip, input logic [DQ_W-1:0] w [4]);
      ctl_u.nop(skip);
      for (int i = 0; i < 4; i++) begin
         #1;
         `CHK(dq_oe, 1'b1)
         `CHK(dq_out, w[i])
         ctl_u.nop(1);
      end
   endtask

   task automatic wr(input logic [1:0] b, input logic [DQ_W-1:0] d, int n);
      ctl_u.issue(CMD_WR, b, 13'h0000, d, 1'b0, 1'b1);
      for (int i = 1; i < n; i++) begin
         ctl_u.issue(CMD_NOP, 2'h0, 13'h0000, d + 16'(i), 1'b0, 1'b1);
      end
   endtask

   task automatic wait_bank(input int b, input sdc_bank_st_t e, int lim);
      #1;
      for (int i = 0; i < lim && bank_state[b] !== e; i++) begin
         ctl_u.nop(1);
         #1;
      end
      `CHK(bank_state[b], e)
   endtask

   // keeps the clock enable level that the caller left
   task automatic wait_pw(input sdc_pwr_t e, int lim);
      #1;
      for (int i = 0; i < lim && pwr_state !== e; i++) begin
         ctl_u.nop(1, ctl_u.pins.cke);
         #1;
      end
      `CHK(pwr_state, e)
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      #1;
      `CHK(mode_loaded, 1'b0)
      `CHK(bank_state, {4{BK_IDLE}})
      `CHK(pwr_state, PW_RUN)
      `CHK(dq_oe, 1'b0)
   endtask

   // BL4, sequential, CL2, normal mode, burst writes
   task automatic t_init;
      ctl_u.init(10'h022);
      #1;
      `CHK(mode_word, 10'h022)
      `CHK(mode_loaded, 1'b1)
      `CHK(mode_reserved, 1'b0)
      for (int b = 0; b < 4; b++) begin
         ctl_u.cmd(CMD_ACT, 2'(b), 13'h0000);
      end
      ctl_u.nop(int'(RCD_CYC) + 4);
      #1;
      `CHK(bank_state, {4{BK_ACTV}})
   endtask

   // third write cuts the second after two words; wrapped and cut reads
   task automatic t_wr_wr;
      wr(2'h0, 16'hA000, 4);
      ctl_u.nop(2);
      wr(2'h0, 16'hC000, 2);
      wr(2'h1, 16'hB000, 4);
      ctl_u.nop(4);
      ctl_u.cmd(CMD_RD, 2'h0, 13'h0002);
      rd_words(4, '{16'hA002, 16'hA003, 16'hC000, 16'hC001});
      ctl_u.cmd(CMD_RD, 2'h0, 13'h0000);
      ctl_u.cmd(CMD_RD, 2'h1, 13'h0000);
      rd_words(3, '{16'hC000, 16'hB000, 16'hB001, 16'hB002});
   endtask

   // read cuts a write; write cuts a read after a masked cycle
   task automatic t_rd_wr;
      wr(2'h0, 16'hE000, 2);
      ctl_u.cmd(CMD_RD, 2'h1, 13'h0000);
      rd_words(4, '{16'hB000, 16'hB001, 16'hB002, 16'hB003});
      ctl_u.cmd(CMD_RD, 2'h0, 13'h0000);
      rd_words(4, '{16'hE000, 16'hE001, 16'hA002, 16'hA003});
      ctl_u.cmd(CMD_RD, 2'h0, 13'h0000);
      ctl_u.cmd(CMD_NOP, 2'h0, 13'h0000, 1'b1);
      wr(2'h1, 16'hF000, 4);
      #1;
      `CHK(dq_oe, 1'b0)
      ctl_u.nop(1);
      #1;
      `CHK(dq_oe, 1'b0)
      ctl_u.cmd(CMD_RD, 2'h1, 13'h0000);
      rd_words(4, '{16'hF000, 16'hF001, 16'hF002, 16'hF003});
   endtask

   // interrupted auto precharge bursts close their own banks
   task automatic t_ap;
      ctl_u.cmd(CMD_RD, 2'h0, 13'h0400);
      ctl_u.cmd(CMD_RD, 2'h1, 13'h0000);
      wait_bank(0, BK_PRE, 4);
      wait_bank(0, BK_IDLE, int'(RP_CYC) + 3);
      // read with auto precharge cut by a write, masked two clocks ahead
      ctl_u.cmd(CMD_RD, 2'h1, 13'h0400);
      ctl_u.cmd(CMD_NOP, 2'h0, 13'h0000, 1'b1);
      ctl_u.cmd(CMD_NOP, 2'h0, 13'h0000, 1'b1);
      ctl_u.issue(CMD_WR, 2'h3, 13'h0000, 16'h7200, 1'b0, 1'b1);
      ctl_u.nop(1);
      #1;
      `CHK(dq_out, 16'hF000)
      ctl_u.nop(1);
      #1;
      `CHK(dq_oe, 1'b0)
      ctl_u.nop(1);
      #1;
      `CHK(dq_oe, 1'b0)
      `CHK(bank_state[1], BK_PRE)
      ctl_u.issue(CMD_WR, 2'h2, 13'h0400, 16'h7000, 1'b0, 1'b1);
      ctl_u.issue(CMD_WR, 2'h3, 13'h0000, 16'h7100, 1'b0, 1'b1);
      wait_bank(2, BK_REC, 4);
      wait_bank(2, BK_PRE, int'(WR_CYC) + 1);
   endtask

   task automatic t_power;
      ctl_u.pre_all();
      ctl_u.nop(1, 1'b0);
      wait_pw(PW_PDN, 6);
      ctl_u.nop(1);
      ctl_u.cmd(CMD_ACT, 2'h0, 13'h0000);
      wait_bank(0, BK_ACTV, int'(RCD_CYC) + 5);
      ctl_u.pre_all();
      ctl_u.issue(CMD_BST, 2'h0, 13'h0000, 16'h0000, 1'b0, 1'b0);
      wait_pw(PW_DEEP, 6);
      ctl_u.nop(2);
      wait_pw(PW_RUN, 6);
      `CHK(mode_word, 10'h022)
      ctl_u.issue(CMD_AREF, 2'h0, 13'h0000, 16'h0000, 1'b0, 1'b0);
      wait_pw(PW_SREF, 6);
      ctl_u.sref_exit();
      wait_pw(PW_RUN, 4);
      ctl_u.cmd(CMD_ACT, 2'h1, 13'h0000);
      ctl_u.nop(int'(RCD_CYC) + 2);
      ctl_u.cmd(CMD_RD, 2'h1, 13'h0000);
      ctl_u.nop(1, 1'b0);
      wait_pw(PW_SUSP, 6);
      ctl_u.nop(1);
      wait_pw(PW_RUN, 4);
      ctl_u.nop(6);
      ctl_u.pre_all();
   endtask

   // reserved codes flagged; CL3 with single-location writes
   task automatic t_mode;
      ctl_u.load_mode(10'h012);
      #1;
      `CHK(mode_reserved, 1'b1)
      ctl_u.load_mode(10'h0A2);
      #1;
      `CHK(mode_reserved, 1'b1)
      ctl_u.load_mode(10'h232);
      #1;
      `CHK(mode_reserved, 1'b0)
      `CHK(mode_word, 10'h232)
      ctl_u.cmd(CMD_ACT, 2'h0, 13'h0000);
      ctl_u.nop(int'(RCD_CYC) + 1);
      wr(2'h0, 16'h6000, 4);
      ctl_u.nop(2);
      ctl_u.cmd(CMD_RD, 2'h0, 13'h0000);
      rd_words(5, '{16'h6000, 16'hE001, 16'hA002, 16'hA003});
      // terminate after the first beat: one word, then a quiet bus
      ctl_u.cmd(CMD_RD, 2'h0, 13'h0000);
      ctl_u.cmd(CMD_BST, 2'h0, 13'h0000);
      ctl_u.nop(4);
      #1;
      `CHK(dq_out, 16'h6000)
      `CHK(bank_state[0], BK_ACTV)
      ctl_u.nop(1);
      #1;
      `CHK(dq_oe, 1'b0)
   endtask

   // reset held 20 cycles, then the scenarios in order
   initial begin
      reset_n = 1'b0;
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      t_reset();
      t_init();
      t_wr_wr();
      t_rd_wr();
      t_ap();
      t_power();
      t_mode();
      tally_and_finish();
   end
endmodule
